// file: hw/ptcs_defines.svh
// Constants for the transceiver state and carrier sense block
`ifndef PTCS_DEFINES_SVH
`define PTCS_DEFINES_SVH
`define PTCS_SLOT_PREAMBLE_COUNT 8
`define PTCS_SYNC_TIMEOUT_SYMBOLS 4
`define PTCS_SYMBOL_DIV 40
`define PTCS_CARRIER_DIV 4
`endif

// file: hw/ptcs_pkg.sv
// Types for the transceiver state and carrier sense block
package ptcs_pkg;
  typedef enum logic [0:0] {
    PTCS_TX_ON_RX_OFF = 1'b0,
    PTCS_TX_OFF_RX_ON = 1'b1
  } ptcs_trx_state_t;
  typedef enum logic [1:0] {
    PTCS_SUCCESS = 2'b00,
    PTCS_BUSY_TX = 2'b01,
    PTCS_BUSY_RX = 2'b10
  } ptcs_trx_status_t;
  typedef enum logic [0:0] {
    PTCS_IDLE = 1'b0,
    PTCS_BUSY = 1'b1
  } ptcs_media_t;
  typedef enum logic [1:0] {
    PTCS_CS_HUNT  = 2'b00,
    PTCS_CS_SYNC  = 2'b01,
    PTCS_CS_FRAME = 2'b10
  } ptcs_cs_state_t;
endpackage

// file: hw/ptcs_timebase.sv
// Common clock divider giving carrier and symbol enables
`timescale 1ns/10ps
`include "ptcs_defines.svh"
module ptcs_timebase
  import ptcs_pkg::*;
#(
  parameter int CARRIER_DIV = `PTCS_CARRIER_DIV,
  parameter int SYMBOL_DIV  = `PTCS_SYMBOL_DIV
) (
  input  wire logic ref_clk,
  input  wire logic nrst,
  output logic      carrier_tick,
  output logic      symbol_tick
);
  // Counters are 16 bits wide, and a one-cycle tick needs a divider of at least two
  if (CARRIER_DIV < 2 || SYMBOL_DIV < 2 || CARRIER_DIV > 65535 || SYMBOL_DIV > 65535) begin : g_bad_div
    $error("ptcs_timebase: divider out of range");
  end
  logic [15:0] car_cnt;
  logic [15:0] sym_cnt;
  logic [15:0] next_car_cnt;
  logic [15:0] next_sym_cnt;
  // Both rates come from two counters on one clock, reset together, so they never drift apart
  always_comb begin
    next_car_cnt = (car_cnt == 16'(CARRIER_DIV - 1)) ? 16'h0000 : car_cnt + 16'h0001;
    next_sym_cnt = (sym_cnt == 16'(SYMBOL_DIV - 1)) ? 16'h0000 : sym_cnt + 16'h0001;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      car_cnt      <= 16'h0000;
      sym_cnt      <= 16'h0000;
      carrier_tick <= 1'b0;
      symbol_tick  <= 1'b0;
    end else begin
      car_cnt      <= next_car_cnt;
      sym_cnt      <= next_sym_cnt;
      carrier_tick <= (car_cnt == 16'(CARRIER_DIV - 1));
      symbol_tick  <= (sym_cnt == 16'(SYMBOL_DIV - 1));
    end
  end
  period_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    symbol_tick |=> !symbol_tick) else $error("symbol tick lasted more than one cycle");
endmodule

// file: hw/ptcs_top.sv
// Transceiver state control and physical carrier sense
`timescale 1ns/10ps
`include "ptcs_defines.svh"
module ptcs_top
  import ptcs_pkg::*;
#(
  parameter int SLOT_PREAMBLE_COUNT = `PTCS_SLOT_PREAMBLE_COUNT,
  parameter int SYNC_TIMEOUT        = `PTCS_SYNC_TIMEOUT_SYMBOLS
) (
  input  wire logic REF_CLK,
  input  wire logic NRST,
  input  wire logic TRANSCEIVER_STATE_REQUEST,
  input  wire logic REQ_STATE,
  input  wire logic TX_ACTIVE,
  input  wire logic RX_ACTIVE,
  input  wire logic CARRIER_SENSE_QUERY,
  input  wire logic PREAMBLE_SYMBOL,
  input  wire logic FRAME_SYNC,
  input  wire logic FRAME_END,
  output logic      TRX_CONFIRM,
  output logic [1:0] TRX_STATUS,
  output logic      TX_ENABLE,
  output logic      RX_ENABLE,
  output logic      CS_CONFIRM,
  output logic      CS_STATUS,
  output logic      PHYSICAL_CARRIER_SENSE,
  output logic      CARRIER_TICK,
  output logic      SYMBOL_TICK
);
  // Preamble and sync counters are 8 bits wide, so larger counts would wrap
  if (SLOT_PREAMBLE_COUNT < 1 || SLOT_PREAMBLE_COUNT > 255 || SYNC_TIMEOUT < 1 || SYNC_TIMEOUT > 255)
  begin : g_bad_count
    $error("ptcs_top: count parameter out of range");
  end
  logic carrier_tick;
  logic symbol_tick;
  // One divider feeds both carrier and symbol timing
  ptcs_timebase u_timebase (
    .ref_clk      (REF_CLK),
    .nrst         (NRST),
    .carrier_tick (carrier_tick),
    .symbol_tick  (symbol_tick)
  );
  // Transceiver state request handling
  logic             tx_en;
  logic             rx_en;
  logic             trx_cf;
  ptcs_trx_status_t trx_st;
  logic             next_tx_en;
  logic             next_rx_en;
  logic             next_trx_cf;
  ptcs_trx_status_t next_trx_st;
  always_comb begin
    next_tx_en  = tx_en;
    next_rx_en  = rx_en;
    next_trx_cf = 1'b0;
    next_trx_st = trx_st;
    if (TRANSCEIVER_STATE_REQUEST) begin
      next_trx_cf = 1'b1;
      // Busy transmit checked first: an ongoing send must not be cut
      if (TX_ACTIVE) begin
        next_trx_st = PTCS_BUSY_TX;
      end else if (RX_ACTIVE) begin
        next_trx_st = PTCS_BUSY_RX;
      end else begin
        next_trx_st = PTCS_SUCCESS;
        next_tx_en  = (REQ_STATE == PTCS_TX_ON_RX_OFF);
        next_rx_en  = (REQ_STATE == PTCS_TX_OFF_RX_ON);
      end
    end
  end
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      tx_en  <= 1'b0;
      rx_en  <= 1'b1;
      trx_cf <= 1'b0;
      trx_st <= PTCS_SUCCESS;
    end else begin
      tx_en  <= next_tx_en;
      rx_en  <= next_rx_en;
      trx_cf <= next_trx_cf;
      trx_st <= next_trx_st;
    end
  end
  // Carrier sense machine; preamble and sync counts advance per symbol, sync and frame end act at once
  ptcs_cs_state_t cs_st;
  ptcs_cs_state_t next_cs_st;
  logic [7:0]     pre_cnt;
  logic [7:0]     next_pre_cnt;
  logic [7:0]     sync_cnt;
  logic [7:0]     next_sync_cnt;
  always_comb begin
    next_cs_st    = cs_st;
    next_pre_cnt  = pre_cnt;
    next_sync_cnt = sync_cnt;
    unique case (cs_st)
      PTCS_CS_HUNT: begin
        if (symbol_tick) begin
          if (!PREAMBLE_SYMBOL) begin
            next_pre_cnt = 8'h00;
          end else if (pre_cnt == 8'(SLOT_PREAMBLE_COUNT - 1)) begin
            next_pre_cnt  = 8'h00;
            next_sync_cnt = 8'h00;
            next_cs_st    = PTCS_CS_SYNC;
          end else begin
            next_pre_cnt = pre_cnt + 8'h01;
          end
        end
      end
      PTCS_CS_SYNC: begin
        if (FRAME_SYNC) begin
          next_cs_st = PTCS_CS_FRAME;
        end else if (symbol_tick) begin
          // Give up after the timeout so a false preamble cannot hold the media
          if (sync_cnt == 8'(SYNC_TIMEOUT - 1)) begin
            next_cs_st = PTCS_CS_HUNT;
          end else begin
            next_sync_cnt = sync_cnt + 8'h01;
          end
        end
      end
      PTCS_CS_FRAME: begin
        if (FRAME_END) begin
          next_cs_st = PTCS_CS_HUNT;
        end
      end
      default: begin
        next_cs_st = PTCS_CS_HUNT;
      end
    endcase
  end
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      cs_st    <= PTCS_CS_HUNT;
      pre_cnt  <= 8'h00;
      sync_cnt <= 8'h00;
    end else begin
      cs_st    <= next_cs_st;
      pre_cnt  <= next_pre_cnt;
      sync_cnt <= next_sync_cnt;
    end
  end
  // Query answer, registered outputs
  logic next_pcs;
  logic physical_carrier_sense;
  logic cs_cf;
  logic cs_stat;
  always_comb begin
    next_pcs = (next_cs_st != PTCS_CS_HUNT);
  end
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      physical_carrier_sense     <= 1'b0;
      cs_cf   <= 1'b0;
      cs_stat <= PTCS_IDLE;
    end else begin
      physical_carrier_sense     <= next_pcs;
      cs_cf   <= CARRIER_SENSE_QUERY;
      cs_stat <= physical_carrier_sense ? PTCS_BUSY : PTCS_IDLE;
    end
  end
  // Output flops
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      TRX_CONFIRM            <= 1'b0;
      TRX_STATUS             <= 2'h0;
      TX_ENABLE              <= 1'b0;
      RX_ENABLE              <= 1'b1;
      CS_CONFIRM             <= 1'b0;
      CS_STATUS              <= 1'b0;
      PHYSICAL_CARRIER_SENSE <= 1'b0;
      CARRIER_TICK           <= 1'b0;
      SYMBOL_TICK            <= 1'b0;
    end else begin
      TRX_CONFIRM            <= trx_cf;
      TRX_STATUS             <= trx_st;
      TX_ENABLE              <= tx_en;
      RX_ENABLE              <= rx_en;
      CS_CONFIRM             <= cs_cf;
      CS_STATUS              <= cs_stat;
      PHYSICAL_CARRIER_SENSE <= physical_carrier_sense;
      CARRIER_TICK           <= carrier_tick;
      SYMBOL_TICK            <= symbol_tick;
    end
  end
  sequence req_idle_s;
    TRANSCEIVER_STATE_REQUEST && !TX_ACTIVE && !RX_ACTIVE;
  endsequence
  trx_success_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    req_idle_s |-> ##2 (TRX_CONFIRM && TRX_STATUS == PTCS_SUCCESS)) else $error("missing success confirm");
  busy_tx_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    TRANSCEIVER_STATE_REQUEST && TX_ACTIVE |-> ##2 (TRX_CONFIRM && TRX_STATUS == PTCS_BUSY_TX))
    else $error("missing busy tx status");
  busy_rx_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    TRANSCEIVER_STATE_REQUEST && !TX_ACTIVE && RX_ACTIVE |-> ##2 (TRX_STATUS == PTCS_BUSY_RX))
    else $error("missing busy rx status");
  busy_hold_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    TRANSCEIVER_STATE_REQUEST && (TX_ACTIVE || RX_ACTIVE)
    |-> ##2 (TX_ENABLE == $past(TX_ENABLE) && RX_ENABLE == $past(RX_ENABLE)))
    else $error("enables changed on busy request");
  state_apply_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    req_idle_s ##0 (REQ_STATE == PTCS_TX_ON_RX_OFF) |-> ##2 (TX_ENABLE && !RX_ENABLE))
    else $error("transmit state not applied");
  cs_answer_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    CARRIER_SENSE_QUERY |-> ##2 CS_CONFIRM) else $error("query not answered");
  cs_busy_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    CS_CONFIRM |-> (CS_STATUS == ($past(cs_st, 2) != PTCS_CS_HUNT))) else $error("media status mismatch");
  pcs_rise_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $rose(physical_carrier_sense) |-> $past(cs_st) == PTCS_CS_HUNT && $past(PREAMBLE_SYMBOL) && $past(symbol_tick))
    else $error("carrier sense rose without preamble");
  pcs_drop_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (cs_st == PTCS_CS_SYNC && symbol_tick && !FRAME_SYNC && sync_cnt == 8'(SYNC_TIMEOUT - 1)) |=> !physical_carrier_sense)
    else $error("carrier sense held after sync failure");
endmodule

// file: tb/ptcs_line_model.sv
// Line-side model: preamble symbols and frame sync for the carrier sense logic
`timescale 1ns/10ps
module ptcs_line_model (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       symbol_tick,
  input  wire logic       start,
  input  wire logic [3:0] pre_len,
  input  wire logic       sync_ok,
  output logic            preamble_symbol,
  output logic            frame_sync
);
  logic [3:0] left;
  logic       armed;
  // Preamble lasts pre_len symbol ticks; sync follows one symbol later if armed
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      left <= 4'h0;
      armed <= 1'b0;
      preamble_symbol <= 1'b0;
      frame_sync <= 1'b0;
    end else begin
      frame_sync <= 1'b0;
      if (start) begin
        left <= pre_len;
        preamble_symbol <= 1'b1;
        armed <= sync_ok;
      end else if (symbol_tick && left != 4'h0) begin
        left <= left - 4'h1;
        if (left == 4'h1) preamble_symbol <= 1'b0;
      end else if (symbol_tick && armed) begin
        armed <= 1'b0;
        frame_sync <= 1'b1;
      end
    end
  end
endmodule

// file: tb/ptcs_top_bench.sv
// Self-checking bench for transceiver state and carrier sense
`timescale 1ns/10ps
module ptcs_top_bench;
  import ptcs_pkg::*;
  logic ref_clk = 0, nrst = 0, req = 0, req_state = 0, tx_act = 0, rx_act = 0, query = 0, frame_end = 0;
  logic start = 0, sync_ok = 0, tx_m = 0, rx_m = 1;
  logic [3:0] pre_len = 4'h0;
  logic pre_sym, f_sync, trx_cf, tx_en, rx_en, cs_cf, cs_st, physical_carrier_sense, c_tick, s_tick;
  logic [1:0] trx_st;
  logic [3:0] trx_q[$];
  logic       cs_q[$];
  int err_count = 0, samples_checked = 0, seed = 32'h545769d9, n;
  ptcs_top ptcs_top_i (.REF_CLK(ref_clk), .NRST(nrst), .TRANSCEIVER_STATE_REQUEST(req), .REQ_STATE(req_state),
    .TX_ACTIVE(tx_act), .RX_ACTIVE(rx_act), .CARRIER_SENSE_QUERY(query), .PREAMBLE_SYMBOL(pre_sym),
    .FRAME_SYNC(f_sync), .FRAME_END(frame_end), .TRX_CONFIRM(trx_cf), .TRX_STATUS(trx_st), .TX_ENABLE(tx_en),
    .RX_ENABLE(rx_en), .CS_CONFIRM(cs_cf), .CS_STATUS(cs_st), .PHYSICAL_CARRIER_SENSE(physical_carrier_sense),
    .CARRIER_TICK(c_tick), .SYMBOL_TICK(s_tick));
  ptcs_line_model ptcs_line_model_i (.ref_clk(ref_clk), .nrst(nrst), .symbol_tick(s_tick), .start(start),
    .pre_len(pre_len), .sync_ok(sync_ok), .preamble_symbol(pre_sym), .frame_sync(f_sync));
  always #12.5 ref_clk = ~ref_clk;
  task check(input logic [3:0] seen, input logic [3:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task clk(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // Request stays high across calls so back-to-back pulses never double-assign
  task trx(input logic st, input logic t, input logic r);
    req <= 1'b1;
    req_state <= st;
    tx_act <= t;
    rx_act <= r;
    if (!t && !r) begin
      tx_m = !st;
      rx_m = st;
    end
    trx_q.push_back({t ? PTCS_BUSY_TX : r ? PTCS_BUSY_RX : PTCS_SUCCESS, tx_m, rx_m});
    @(posedge ref_clk);
  endtask
  task qry(input logic busy);
    query <= 1'b1;
    cs_q.push_back(busy);
    clk(1);
    query <= 1'b0;
    clk(3);
  endtask
  // Preamble of len symbols, optional sync, then carrier sense checks
  task cs_case(input logic [3:0] len, input logic sy);
    @(posedge ref_clk iff s_tick === 1'b1);
    clk(20);
    start <= 1'b1;
    pre_len <= len;
    sync_ok <= sy;
    clk(1);
    start <= 1'b0;
    repeat (len) @(posedge ref_clk iff s_tick === 1'b1);
    clk(4);
    check({3'b0, physical_carrier_sense}, {3'b0, len >= 4'h8}, "carrier sense rise");
    qry(len >= 4'h8);
    repeat (6) @(posedge ref_clk iff s_tick === 1'b1);
    clk(2);
    check({3'b0, physical_carrier_sense}, {3'b0, sy && len >= 4'h8}, "carrier sense hold");
    qry(sy && len >= 4'h8);
    if (sy) begin
      frame_end <= 1'b1;
      clk(1);
      frame_end <= 1'b0;
      clk(4);
      check({3'b0, physical_carrier_sense}, 4'h0, "carrier sense after frame");
    end
  endtask
  // Monitor pairs each confirm with the oldest note; 4'hf marks an unexpected confirm
  always @(posedge ref_clk) begin
    if (trx_cf === 1'b1) check({trx_st, tx_en, rx_en}, trx_q.size() ? trx_q.pop_front() : 4'hf, "trx");
    if (cs_cf === 1'b1) check({3'b0, cs_st}, cs_q.size() ? {3'b0, cs_q.pop_front()} : 4'hf, "cs");
  end
  initial begin
    clk(12);
    nrst <= 1'b1;
    clk(2);
    check({tx_en, rx_en, physical_carrier_sense, trx_cf}, 4'b0100, "reset state");
    $display("test reset done");
    trx(1'b0, 1'b1, 1'b1);
    for (n = 0; n < 32; n++) trx(1'($random(seed)), ($random(seed) & 3) == 0, ($random(seed) & 3) == 1);
    req <= 1'b0;
    tx_act <= 1'b0;
    rx_act <= 1'b0;
    clk(4);
    $display("test state requests done");
    n = 0;
    @(posedge ref_clk iff s_tick === 1'b1);
    do begin
      @(posedge ref_clk);
      n += c_tick;
    end while (s_tick !== 1'b1);
    check(4'(n), 4'ha, "carrier ticks per symbol");
    $display("test timebase done");
    cs_case(4'h7, 1'b1);
    cs_case(4'h8, 1'b0);
    cs_case(4'h8, 1'b1);
    clk(10);
    check({2'b0, trx_q.size() == 0, cs_q.size() == 0}, 4'h3, "confirms all seen");
    $display("test carrier sense done");
    test_done;
  end
  // Watchdog well beyond the expected few thousand cycles
  initial begin
    #500000;
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done;
  end
endmodule
